/* File: pkg/swta_defines.svh */
// register indices, field positions, reset values and keys for the
// stop, wake and timed access block; included by package and module.
// Overview of operation
// - setting stop request enters the Stop state
// - only external interrupt, power-fail interrupt or reset leaves Stop
// - Stop halts crystal and all clocks; restart needed
// - band-gap keep bit holds reference on in Stop
// - band-gap keep bit resets to zero
// - keep bit ignored in run; in Idle it gates the power-fail wake
// - kept reference lets power-fail interrupt/reset wake
// - ring select runs from ring right after Stop
// - ring fast start only on interrupt wake
// - ring select clear waits for crystal
// - switch ring to crystal after 65536 clocks
// - Stop during ring period stops all clocks
// - ring active flag shows ring supplies clock
// - AA then 55 opens three-cycle window
// - protected write without unlock is ignored
// - protected: keep bit, power-on reset flag, watchdog enable, restart and irq flag
`ifndef SWTA_DEFINES_SVH
`define SWTA_DEFINES_SVH

// register indices; byte address is four times the index
`define SWTA_IDX_PWR 10'h087
`define SWTA_IDX_XFLAG 10'h091
`define SWTA_IDX_KEY 10'h0C7
`define SWTA_IDX_WDPWR 10'h0D8
`define SWTA_IDX_ISTA 10'h0F4
`define SWTA_IDX_IMSK 10'h0F5

// power control fields
`define SWTA_PC_IDLE 0
`define SWTA_PC_STOP 1
// extended flag fields
`define SWTA_XF_KEEP 0
`define SWTA_XF_RSEL 1
`define SWTA_XF_RACT 2
// watchdog and power control fields
`define SWTA_WD_RESTART 0
`define SWTA_WD_ENABLE 1
`define SWTA_WD_WTRF 2
`define SWTA_WD_IRQF 3
`define SWTA_WD_PFFLAG 4
`define SWTA_WD_EPFI 5
`define SWTA_WD_POR 6
`define SWTA_WD_SMOD 7
// event status bits
`define SWTA_EV_WAKE 0
`define SWTA_EV_XTAL 1
`define SWTA_EV_PFW 2
`define SWTA_EV_TAVIOL 3
`define SWTA_EV_N 4

// timed access keys and window length in cycles
`define SWTA_KEY_FIRST 8'hAA
`define SWTA_KEY_SECOND 8'h55
`define SWTA_KEY_WIN 2'h3
// crystal clocks before leaving the ring
`define SWTA_RING_CLKS 65536
`define SWTA_RING_W 17
// reset values
`define SWTA_RST_POR 1'h1
`define SWTA_RST_BGS 1'h0

`endif

/* File: pkg/swta_pkg.sv */
// types for the stop, wake and timed access block
// assumes swta_defines.svh is on the include path
`include "swta_defines.svh"

package swta_pkg;

  typedef enum logic [1:0] {
    SWTA_RUN,
    SWTA_STOP,
    SWTA_RING,
    SWTA_XWAIT
  } swta_mode_t;

  typedef struct packed {
    swta_mode_t mode;
    logic bandgap_stop_keep;
    logic ring_select;
    logic idle;
    logic smod;
    logic por;
    logic epfi;
    logic powerfail_interrupt;
    logic watchdog_irq_flag;
    logic wtrf;
    logic watchdog_enable_bit;
    logic watchdog_restart_bit;
    logic key_armed;
    logic [1:0] key_win;
    logic [`SWTA_RING_W-1:0] ring_cnt;
    logic [`SWTA_EV_N-1:0] ista;
    logic [`SWTA_EV_N-1:0] imsk;
    logic [31:0] prdata;
    logic [1:0] xirq_s;
    logic [1:0] pfw_s;
    logic [1:0] pfr_s;
    logic [1:0] xst_s;
  } swta_regs_t;

endpackage : swta_pkg

/* File: verilog/swta_top.sv */
// stop mode control, ring oscillator wake and timed access gate
// assumes pclk keeps running as control clock while the core sleeps
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "swta_defines.svh"

module swta_top #(
  parameter int RING_SWITCH_CLKS = `SWTA_RING_CLKS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins, asynchronous
  input wire logic ext_irq_in,
  input wire logic pfail_warn_in,
  input wire logic pfail_rst_in,
  input wire logic xtal_stable_in,
  // watchdog side, same clock
  input wire logic wd_irq_set,
  input wire logic wd_rst_seen,
  output logic wd_enable,
  output logic wd_restart,
  // clock and power control
  output logic xtal_osc_en,
  output logic ring_osc_en,
  output logic clk_sel_ring,
  output logic core_clk_en,
  output logic bandgap_en,
  output logic pfail_reset,
  output logic idle_mode,
  output logic stop_mode,
  // interrupt
  output logic irq
);
  import swta_pkg::*;

  // reset image, constants only
  localparam swta_regs_t REGS_RST = '{
    mode: SWTA_RUN,
    bandgap_stop_keep: `SWTA_RST_BGS,
    por: `SWTA_RST_POR,
    default: '0
  };

  swta_regs_t r_q;
  swta_regs_t r_d;

  logic acc_wr;
  logic setup;
  logic [9:0] idx;
  logic hit;
  logic [7:0] wb;
  logic key_open;
  logic prot_hit;
  logic [`SWTA_EV_N-1:0] ev;
  logic [7:0] rd_pwr;
  logic [7:0] rd_xf;
  logic [7:0] rd_wd;
  logic [31:0] rd_mux;
  logic irq_wake;
  logic pfi_wake;

  //////////////////////////////////////////////////////////////////////
  // bus decode and read views
  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & pwrite;
  assign idx = paddr[11:2];
  assign wb = pwdata[7:0];
  assign hit = (paddr[1:0] == 2'h0) &&
               (idx == `SWTA_IDX_PWR || idx == `SWTA_IDX_XFLAG ||
                idx == `SWTA_IDX_KEY || idx == `SWTA_IDX_WDPWR ||
                idx == `SWTA_IDX_ISTA || idx == `SWTA_IDX_IMSK);
  assign key_open = (r_q.key_win != 2'h0);

  always_comb begin
    rd_pwr = 8'h00;
    rd_pwr[`SWTA_PC_IDLE] = r_q.idle;
    rd_pwr[`SWTA_PC_STOP] = (r_q.mode == SWTA_STOP);
    rd_xf = 8'h00;
    rd_xf[`SWTA_XF_KEEP] = r_q.bandgap_stop_keep;
    rd_xf[`SWTA_XF_RSEL] = r_q.ring_select;
    rd_xf[`SWTA_XF_RACT] = (r_q.mode == SWTA_RING);
    rd_wd = 8'h00;
    rd_wd[`SWTA_WD_SMOD] = r_q.smod;
    rd_wd[`SWTA_WD_POR] = r_q.por;
    rd_wd[`SWTA_WD_EPFI] = r_q.epfi;
    rd_wd[`SWTA_WD_PFFLAG] = r_q.powerfail_interrupt;
    rd_wd[`SWTA_WD_IRQF] = r_q.watchdog_irq_flag;
    rd_wd[`SWTA_WD_WTRF] = r_q.wtrf;
    rd_wd[`SWTA_WD_ENABLE] = r_q.watchdog_enable_bit;
    rd_mux = 32'h0000_0000;
    if (paddr[1:0] == 2'h0) begin
      case (idx)
        `SWTA_IDX_PWR: rd_mux[7:0] = rd_pwr;
        `SWTA_IDX_XFLAG: rd_mux[7:0] = rd_xf;
        `SWTA_IDX_WDPWR: rd_mux[7:0] = rd_wd;
        `SWTA_IDX_ISTA: rd_mux[`SWTA_EV_N-1:0] = r_q.ista;
        `SWTA_IDX_IMSK: rd_mux[`SWTA_EV_N-1:0] = r_q.imsk;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // wake causes seen from the second synchroniser stage
  assign pfi_wake = r_q.bandgap_stop_keep & r_q.epfi & r_q.pfw_s[1];
  assign irq_wake = r_q.xirq_s[1] | pfi_wake;

  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_d = r_q;
    ev = '0;
    prot_hit = 1'h0;
    r_d.watchdog_restart_bit = 1'h0;

    // pin synchronisers
    r_d.xirq_s = {r_q.xirq_s[0], ext_irq_in};
    r_d.pfw_s = {r_q.pfw_s[0], pfail_warn_in};
    r_d.pfr_s = {r_q.pfr_s[0], pfail_rst_in};
    r_d.xst_s = {r_q.xst_s[0], xtal_stable_in};

    if (setup) begin
      r_d.prdata = rd_mux;
    end

    // unlock window ages every cycle
    if (key_open) begin
      r_d.key_win = r_q.key_win - 2'h1;
    end

    if (acc_wr) begin
      r_d.key_armed = 1'h0;
      if (idx == `SWTA_IDX_KEY && paddr[1:0] == 2'h0) begin
        if (wb == `SWTA_KEY_FIRST) begin
          r_d.key_armed = 1'h1;
          r_d.key_win = 2'h0;
        end else if (wb == `SWTA_KEY_SECOND && r_q.key_armed) begin
          r_d.key_win = `SWTA_KEY_WIN;
        end else begin
          r_d.key_win = 2'h0;
        end
      end
      if (idx == `SWTA_IDX_PWR && paddr[1:0] == 2'h0) begin
        r_d.idle = wb[`SWTA_PC_IDLE];
        if (wb[`SWTA_PC_STOP]) begin
          r_d.mode = SWTA_STOP;
          r_d.idle = 1'b0;
        end
      end
      if (idx == `SWTA_IDX_XFLAG && paddr[1:0] == 2'h0) begin
        r_d.ring_select = wb[`SWTA_XF_RSEL];
        if (wb[`SWTA_XF_KEEP] != r_q.bandgap_stop_keep) begin
          prot_hit = 1'h1;
          if (key_open) begin
            r_d.bandgap_stop_keep = wb[`SWTA_XF_KEEP];
          end
        end
      end
      if (idx == `SWTA_IDX_WDPWR && paddr[1:0] == 2'h0) begin
        r_d.smod = wb[`SWTA_WD_SMOD];
        r_d.epfi = wb[`SWTA_WD_EPFI];
        r_d.powerfail_interrupt = r_q.powerfail_interrupt &
                                  wb[`SWTA_WD_PFFLAG];
        r_d.wtrf = r_q.wtrf & wb[`SWTA_WD_WTRF];
        if (wb[`SWTA_WD_POR] != r_q.por ||
            wb[`SWTA_WD_IRQF] != r_q.watchdog_irq_flag ||
            wb[`SWTA_WD_ENABLE] != r_q.watchdog_enable_bit ||
            wb[`SWTA_WD_RESTART]) begin
          prot_hit = 1'h1;
        end
        if (key_open) begin
          r_d.por = wb[`SWTA_WD_POR];
          r_d.watchdog_irq_flag = wb[`SWTA_WD_IRQF];
          r_d.watchdog_enable_bit = wb[`SWTA_WD_ENABLE];
          r_d.watchdog_restart_bit = wb[`SWTA_WD_RESTART];
        end
      end
      if (idx == `SWTA_IDX_ISTA && paddr[1:0] == 2'h0) begin
        r_d.ista = r_q.ista & ~wb[`SWTA_EV_N-1:0];
      end
      if (idx == `SWTA_IDX_IMSK && paddr[1:0] == 2'h0) begin
        r_d.imsk = wb[`SWTA_EV_N-1:0];
      end
      // one protected write spends the window
      if (prot_hit) begin
        if (key_open) begin
          r_d.key_win = 2'h0;
        end else begin
          ev[`SWTA_EV_TAVIOL] = 1'h1;
        end
      end
    end

    // hardware set of flags wins over a software clear
    if (wd_irq_set) begin
      r_d.watchdog_irq_flag = 1'h1;
    end
    if (wd_rst_seen) begin
      r_d.wtrf = 1'h1;
    end
    if (r_q.pfw_s[1] &&
        (r_q.mode != SWTA_STOP || r_q.bandgap_stop_keep)) begin
      r_d.powerfail_interrupt = 1'h1;
      ev[`SWTA_EV_PFW] = 1'h1;
    end

    // idle ends on external interrupt or kept-reference power-fail wake
    if (irq_wake) begin
      r_d.idle = 1'b0;
    end

    // clock mode sequencing
    case (r_q.mode)
      SWTA_RUN: begin
        r_d.ring_cnt = '0;
      end
      SWTA_STOP: begin
        r_d.ring_cnt = '0;
        if (r_q.bandgap_stop_keep && r_q.pfr_s[1]) begin
          r_d.mode = SWTA_XWAIT;
          ev[`SWTA_EV_WAKE] = 1'h1;
        end else if (irq_wake) begin
          ev[`SWTA_EV_WAKE] = 1'h1;
          if (r_q.ring_select) begin
            r_d.mode = SWTA_RING;
          end else begin
            r_d.mode = SWTA_XWAIT;
          end
        end
      end
      SWTA_RING: begin
        if (!(acc_wr && r_d.mode == SWTA_STOP)) begin
          r_d.ring_cnt = r_q.ring_cnt + `SWTA_RING_W'(1);
          if (r_q.ring_cnt ==
              `SWTA_RING_W'(RING_SWITCH_CLKS - 1)) begin
            r_d.mode = SWTA_RUN;
            ev[`SWTA_EV_XTAL] = 1'b1;
          end
        end
      end
      SWTA_XWAIT: begin
        if (r_q.xst_s[1] && !(acc_wr && r_d.mode == SWTA_STOP)) begin
          r_d.mode = SWTA_RUN;
          ev[`SWTA_EV_XTAL] = 1'b1;
        end
      end
      default: begin
        r_d.mode = SWTA_RUN;
      end
    endcase

    r_d.ista = r_d.ista | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= REGS_RST;
    end else begin
      r_q <= r_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata = r_q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wd_enable = r_q.watchdog_enable_bit;
  assign wd_restart = r_q.watchdog_restart_bit;
  assign xtal_osc_en = (r_q.mode != SWTA_STOP);
  assign ring_osc_en = (r_q.mode == SWTA_RING);
  assign clk_sel_ring = (r_q.mode == SWTA_RING);
  assign core_clk_en = (r_q.mode == SWTA_RUN) ||
                       (r_q.mode == SWTA_RING);
  assign bandgap_en = (r_q.mode != SWTA_STOP) |
                      r_q.bandgap_stop_keep;
  assign pfail_reset = bandgap_en & r_q.pfr_s[1];
  assign idle_mode = r_q.idle;
  assign stop_mode = (r_q.mode == SWTA_STOP);
  assign irq = |(r_q.ista & r_q.imsk);

endmodule : swta_top

/* File: tb/swta_top_monitor.sv */
// checker for the stop, wake and timed access block
// bound to swta_top; sees its ports only
`timescale 1ns/100ps
module swta_monitor #(
  parameter int RING_SWITCH_CLKS = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // pins
  input wire logic ext_irq_in,
  input wire logic pfail_warn_in,
  input wire logic pfail_rst_in,
  // watched outputs
  input wire logic wd_enable,
  input wire logic wd_restart,
  input wire logic xtal_osc_en,
  input wire logic ring_osc_en,
  input wire logic clk_sel_ring,
  input wire logic core_clk_en,
  input wire logic bandgap_en,
  input wire logic pfail_reset,
  input wire logic stop_mode
);
  logic wr;
  logic k55;
  logic [16:0] rcnt_q;
  logic [16:0] rcnt_d;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign wr = psel && penable && pwrite;
  assign k55 = wr && paddr == 12'h31C && pwdata[7:0] == 8'h55;
  // ring cycles so far
  always_comb rcnt_d = ring_osc_en ? rcnt_q + 17'h00001 : 17'h00000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rcnt_q <= 17'h00000;
    else rcnt_q <= rcnt_d;
  end
  //////////////////////////////////////////////////////////////////////
  sequence s_key(logic [7:0] k);
    wr && paddr == 12'h31C && pwdata[7:0] == k;
  endsequence
  sequence s_unlock;
    s_key(8'hAA) ##2 s_key(8'h55);
  endsequence
  sequence s_wd_on;
    wr && paddr == 12'h360 && pwdata[1];
  endsequence
  sequence s_quiet;
    !ext_irq_in && !pfail_warn_in && !pfail_rst_in;
  endsequence
  a_stop_enter: assert property (
    wr && paddr == 12'h21C && pwdata[1] |=> stop_mode && !ring_osc_en)
    else $error("stop request not taken");
  a_stop_quiet: assert property (
    s_quiet [*5] ##0 stop_mode |=> stop_mode)
    else $error("stop left without cause");
  a_stop_clks: assert property (
    stop_mode |-> !xtal_osc_en && !core_clk_en && !ring_osc_en)
    else $error("clock running in stop");
  a_bg_run: assert property (!stop_mode |-> bandgap_en)
    else $error("reference off outside stop");
  a_pfr_gate: assert property (pfail_reset |-> bandgap_en)
    else $error("power fail reset without reference");
  a_ring_clock: assert property (
    ring_osc_en |-> clk_sel_ring && core_clk_en && xtal_osc_en)
    else $error("ring period outputs wrong");
  a_ring_span: assert property (
    $fell(ring_osc_en) && !stop_mode |-> rcnt_q == 17'(RING_SWITCH_CLKS))
    else $error("ring period length wrong");
  a_ta_window: assert property (s_unlock ##2 s_wd_on |=> wd_enable)
    else $error("unlocked write lost");
  a_prot_lock: assert property (
    wr && paddr == 12'h360 && !$past(k55, 2) && !$past(k55, 3) &&
    !$past(k55, 4) |=> $stable(wd_enable))
    else $error("locked bit changed");
  a_restart_once: assert property (wd_restart |=> !wd_restart)
    else $error("restart pulse too long");
endmodule : swta_monitor

bind swta_top swta_monitor #(.RING_SWITCH_CLKS(RING_SWITCH_CLKS)) u_mon (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .ext_irq_in(ext_irq_in),
  .pfail_warn_in(pfail_warn_in),
  .pfail_rst_in(pfail_rst_in),
  .wd_enable(wd_enable),
  .wd_restart(wd_restart),
  .xtal_osc_en(xtal_osc_en),
  .ring_osc_en(ring_osc_en),
  .clk_sel_ring(clk_sel_ring),
  .core_clk_en(core_clk_en),
  .bandgap_en(bandgap_en),
  .pfail_reset(pfail_reset),
  .stop_mode(stop_mode)
);

/* File: tb/tb_stop_wake_and_timed_access.sv */
// bench for the stop, wake and timed access block
// drives apb and pins directly; short ring period
`timescale 1ns/100ps
`define CHK(n, e, a) begin \
  samples_checked++; \
  if ((a) !== (e)) begin \
    err_total++; \
    $display("Error %s exp %0h seen %0h", n, e, a); \
  end \
end
module tb_stop_wake_and_timed_access;
  localparam int RN = 16;
  localparam logic [11:0] A_PWR = 12'h21C;
  localparam logic [11:0] A_XF = 12'h244;
  localparam logic [11:0] A_KEY = 12'h31C;
  localparam logic [11:0] A_WD = 12'h360;
  localparam logic [11:0] A_ST = 12'h3D0;
  localparam logic [11:0] A_MK = 12'h3D4;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ext_irq_in, pfail_warn_in, pfail_rst_in, xtal_stable_in;
  logic wd_irq_set, wd_rst_seen, wd_enable, wd_restart, irq;
  logic xtal_osc_en, ring_osc_en, clk_sel_ring, core_clk_en;
  logic bandgap_en, pfail_reset, idle_mode, stop_mode;
  int err_total = 0;
  int samples_checked = 0;
  swta_top #(.RING_SWITCH_CLKS(RN)) dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ext_irq_in(ext_irq_in),
    .pfail_warn_in(pfail_warn_in),
    .pfail_rst_in(pfail_rst_in),
    .xtal_stable_in(xtal_stable_in),
    .wd_irq_set(wd_irq_set),
    .wd_rst_seen(wd_rst_seen),
    .wd_enable(wd_enable),
    .wd_restart(wd_restart),
    .xtal_osc_en(xtal_osc_en),
    .ring_osc_en(ring_osc_en),
    .clk_sel_ring(clk_sel_ring),
    .core_clk_en(core_clk_en),
    .bandgap_en(bandgap_en),
    .pfail_reset(pfail_reset),
    .idle_mode(idle_mode),
    .stop_mode(stop_mode),
    .irq(irq)
  );
  always #5 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////
  task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
  endtask : acc
  task rel;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : rel
  task unlock;
    acc(1'b1, A_KEY, 8'hAA);
    acc(1'b1, A_KEY, 8'h55);
  endtask : unlock
  task final_report;
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, ext_irq_in, pfail_warn_in} = 5'h00;
    {pfail_rst_in, xtal_stable_in, wd_irq_set, wd_rst_seen} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    acc(1'b0, A_XF, 8'h00);
    `CHK("ext flags", 32'h00000000, rd)
    acc(1'b0, A_WD, 8'h00);
    `CHK("wd reg", 32'h00000040, rd)
    acc(1'b1, A_MK, 8'h08);
    acc(1'b1, A_WD, 8'h02);
    rel;
    `CHK("wd locked", 1'b0, wd_enable)
    `CHK("refused irq", 1'b1, irq)
    acc(1'b1, A_ST, 8'h08);
    rel;
    `CHK("irq clear", 1'b0, irq)
    unlock;
    acc(1'b1, A_WD, 8'h23);
    rel;
    `CHK("wd unlocked", 1'b1, wd_enable)
    `CHK("restart", 1'b1, wd_restart)
    unlock;
    rel;
    repeat (4) @(posedge pclk);
    acc(1'b1, A_WD, 8'h20);
    rel;
    `CHK("wd late", 1'b1, wd_enable)
    // stop with reference off, crystal wake
    acc(1'b1, A_PWR, 8'h02);
    rel;
    `CHK("stop", 1'b1, stop_mode)
    `CHK("bg off", 1'b0, bandgap_en)
    `CHK("xtal off", 1'b0, xtal_osc_en)
    pfail_warn_in <= 1'b1;
    repeat (6) @(posedge pclk);
    pfail_warn_in <= 1'b0;
    `CHK("no pf wake", 1'b1, stop_mode)
    ext_irq_in <= 1'b1;
    repeat (5) @(posedge pclk);
    ext_irq_in <= 1'b0;
    `CHK("woken", 1'b0, stop_mode)
    `CHK("no ring", 1'b0, ring_osc_en)
    `CHK("xtal wait", 1'b0, core_clk_en)
    xtal_stable_in <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("run", 1'b1, core_clk_en)
    // idle request and a watchdog flag set by hardware
    acc(1'b1, A_PWR, 8'h01);
    rel;
    `CHK("idle", 1'b1, idle_mode)
    wd_irq_set <= 1'b1;
    @(posedge pclk);
    wd_irq_set <= 1'b0;
    acc(1'b0, A_WD, 8'h00);
    `CHK("wd flag", 32'h0000002A, rd)
    // keep reference, ring wake
    unlock;
    acc(1'b1, A_XF, 8'h03);
    acc(1'b1, A_PWR, 8'h02);
    rel;
    xtal_stable_in <= 1'b0;
    `CHK("bg kept", 1'b1, bandgap_en)
    ext_irq_in <= 1'b1;
    repeat (5) @(posedge pclk);
    ext_irq_in <= 1'b0;
    `CHK("ring on", 1'b1, ring_osc_en)
    acc(1'b0, A_XF, 8'h00);
    `CHK("ring flag", 32'h00000007, rd)
    rel;
    repeat (RN) @(posedge pclk);
    `CHK("ring over", 1'b0, ring_osc_en)
    acc(1'b0, A_XF, 8'h00);
    `CHK("flag clear", 32'h00000003, rd)
    acc(1'b1, A_PWR, 8'h02);
    rel;
    ext_irq_in <= 1'b1;
    repeat (5) @(posedge pclk);
    ext_irq_in <= 1'b0;
    acc(1'b1, A_PWR, 8'h02);
    rel;
    `CHK("ring stop", 1'b0, ring_osc_en)
    `CHK("restop", 1'b1, stop_mode)
    pfail_warn_in <= 1'b1;
    repeat (5) @(posedge pclk);
    pfail_warn_in <= 1'b0;
    `CHK("pf wake", 1'b0, stop_mode)
    repeat (RN + 4) @(posedge pclk);
    acc(1'b1, A_PWR, 8'h02);
    rel;
    pfail_rst_in <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("pf reset", 1'b1, pfail_reset)
    `CHK("pfr wake", 1'b0, stop_mode)
    pfail_rst_in <= 1'b0;
    acc(1'b0, 12'h004, 8'h00);
    `CHK("unmapped", 1'b1, se)
    rel;
    final_report;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    final_report;
  end
endmodule : tb_stop_wake_and_timed_access
